// ---- core/dma_flag_params.svh ----
// Offsets, field positions, reset values and sizes of the DMA flag block
`ifndef DMA_FLAG_PARAMS_SVH
`define DMA_FLAG_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define NUM_CHAN            8
`define FLAGS_PER_CHAN      4

// ----------------------------------------------------------------------
// Register offsets from the controller base (paddr bits 11:0)
// ----------------------------------------------------------------------
`define DMA_BASE_ADDR       32'ha0000000
`define DMA_STATUS_OFS      12'h000
`define DMA_CLEAR_OFS       12'h004
`define CHAN_GROUP0_OFS     12'h008
`define CHAN_GROUP_STRIDE   12'h014
`define CHAN_GROUP_LAST_OFS 12'h094
`define IRQ_PEND_OFS        12'h0a8
`define IRQ_MASK_OFS        12'h0ac

// ----------------------------------------------------------------------
// Field positions inside one channel nibble
// ----------------------------------------------------------------------
`define FLD_ANY             0
`define FLD_CPL             1
`define FLD_HALF            2
`define FLD_ERR             3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FLAG_RST            4'h0
`define CLEAR_RST           32'h00000000
`define PEND_RST            32'h00000000
`define MASK_RST            32'h00000000

`endif

// ---- core/dma_flag_pkg.sv ----
// Types shared by the DMA flag block
package dma_flag_pkg;

  // Register selected by the current bus address
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_STATUS = 3'b001,
    SEL_CLEAR  = 3'b010,
    SEL_GROUP  = 3'b011,
    SEL_PEND   = 3'b100,
    SEL_MASK   = 3'b101
  } reg_sel_type;

endpackage : dma_flag_pkg

// ---- core/chan_flag_cell.sv ----
// Status flags of one DMA channel: set by events, cleared by software
`timescale 1ns/1ps
`include "dma_flag_params.svh"

module chan_flag_cell (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Channel events, one-cycle pulses
  input  wire logic       cpl_event_i,
  input  wire logic       half_event_i,
  input  wire logic       err_event_i,
  // Clear strobes in nibble layout
  input  wire logic [3:0] clear_i,
  // Flag nibble
  output logic      [3:0] flags_o
);

  logic [3:0] set_w;
  logic [3:0] clr_w;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic       any_ev_w;

  // ----------------------------------------------------------------------
  // Set and clear terms
  // ----------------------------------------------------------------------
  // Any event also raises the summary flag
  assign any_ev_w              = cpl_event_i | half_event_i | err_event_i;
  assign set_w[`FLD_ANY]       = any_ev_w;
  assign set_w[`FLD_CPL]       = cpl_event_i;
  assign set_w[`FLD_HALF]      = half_event_i;
  assign set_w[`FLD_ERR]       = err_event_i;
  // The summary clear wipes the whole nibble, the others only their own bit
  assign clr_w[`FLD_ANY]       = clear_i[`FLD_ANY];
  assign clr_w[`FLD_CPL]       = clear_i[`FLD_CPL] | clear_i[`FLD_ANY];
  assign clr_w[`FLD_HALF]      = clear_i[`FLD_HALF] | clear_i[`FLD_ANY];
  assign clr_w[`FLD_ERR]       = clear_i[`FLD_ERR] | clear_i[`FLD_ANY];
  // Set beats clear so an event in the clearing cycle survives
  assign flags_nxt             = set_w | (flags_r & ~clr_w);
  assign flags_o               = flags_r;

  // Flag storage
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_r <= `FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_ALL_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_i[`FLD_ANY] && !any_ev_w |=> flags_o == 4'h0)
    else $error("summary clear left a flag set");
  AST_ZERO_KEEPS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_i == 4'h0 |=> (flags_o & $past(flags_o)) == $past(flags_o))
    else $error("flag dropped without a clear");
  AST_CPL_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_i[`FLD_CPL] && !cpl_event_i && clear_i[`FLD_ANY] == 1'b0 && !half_event_i
    && !err_event_i |=> !flags_o[`FLD_CPL] && flags_o[`FLD_ANY] == $past(flags_o[`FLD_ANY]))
    else $error("complete clear wrong");
  AST_HALF_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_i[`FLD_HALF] && !half_event_i |=> !flags_o[`FLD_HALF])
    else $error("half clear wrong");
  AST_ERR_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_i[`FLD_ERR] && !err_event_i |=> !flags_o[`FLD_ERR])
    else $error("error clear wrong");
  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    any_ev_w && clear_i == 4'hf |=> flags_o == $past(set_w))
    else $error("event lost against clear");

endmodule : chan_flag_cell

// ---- core/dma_flag_clear_logic.sv ----
// APB flag status and write-one-to-clear register block of an eight channel DMA
`timescale 1ns/1ps
`include "dma_flag_params.svh"

module dma_flag_clear_logic (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Channel events from the transfer engine, one-cycle pulses
  input  wire logic [7:0]  transfer_complete_event_i,
  input  wire logic [7:0]  half_transfer_event_i,
  input  wire logic [7:0]  transfer_error_event_i,
  // Flag state and clear strobes towards the engine
  output logic      [31:0] dma_flag_status_o,
  output logic      [31:0] dma_flag_clear_o,
  // Channel group access strobes; chan_group_wr_o pulses after every finished write, group or not
  output logic      [7:0]  chan_group_sel_o,
  output logic      [4:0]  chan_group_off_o,
  output logic             chan_group_wr_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dma_flag_pkg::reg_sel_type sel_w;

  logic [31:0] flags_w;
  logic [31:0] event_w;
  logic [31:0] byte_mask_w;
  logic [31:0] clear_word_w;
  logic [31:0] read_mux_w;
  logic [7:0]  group_hit_w;
  logic [4:0]  group_off_w [0:8];
  logic        setup_w;
  logic        done_w;
  logic        wr_done_w;
  logic        rd_done_w;
  logic        aligned_w;

  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] clear_r;
  logic [31:0] clear_nxt;
  logic [31:0] pend_r;
  logic [31:0] pend_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic        irq_r;
  logic [7:0]  gsel_r;
  logic [7:0]  gsel_nxt;
  logic [4:0]  goff_r;
  logic        gwr_r;

  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  // Setup cycle arms pready; the access completes one cycle later
  assign setup_w    = psel_i & ~penable_i;
  assign done_w     = psel_i & penable_i & pready_r;
  assign wr_done_w  = done_w & pwrite_i;
  assign rd_done_w  = done_w & ~pwrite_i;
  assign aligned_w  = (paddr_i[1:0] == 2'b00);

  // Byte lanes from pstrb; partial writes clear only the enabled lanes
  assign byte_mask_w = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}},
                        {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  // ----------------------------------------------------------------------
  // Channel group decode
  // ----------------------------------------------------------------------
  // Each group spans one stride above its own base
  assign group_off_w[0] = 5'h00;
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHAN; gi++) begin : g_group
      localparam logic [11:0] BASE = 12'(`CHAN_GROUP0_OFS + gi * `CHAN_GROUP_STRIDE);
      logic [11:0] rel_w;
      assign rel_w           = paddr_i - BASE;
      assign group_hit_w[gi] = (paddr_i >= BASE) &&
                               (paddr_i < BASE + `CHAN_GROUP_STRIDE);
      assign group_off_w[gi + 1] = group_off_w[gi] |
                                   (group_hit_w[gi] ? rel_w[4:0] : 5'h00);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  always_comb begin
    if (!aligned_w) begin
      sel_w = dma_flag_pkg::SEL_NONE;
    end else if (paddr_i == `DMA_STATUS_OFS) begin
      sel_w = dma_flag_pkg::SEL_STATUS;
    end else if (paddr_i == `DMA_CLEAR_OFS) begin
      sel_w = dma_flag_pkg::SEL_CLEAR;
    end else if (group_hit_w != 8'h00) begin
      sel_w = dma_flag_pkg::SEL_GROUP;
    end else if (paddr_i == `IRQ_PEND_OFS) begin
      sel_w = dma_flag_pkg::SEL_PEND;
    end else if (paddr_i == `IRQ_MASK_OFS) begin
      sel_w = dma_flag_pkg::SEL_MASK;
    end else begin
      sel_w = dma_flag_pkg::SEL_NONE;
    end
  end

  // Read data; the clear register and channel groups read as zero here
  assign read_mux_w =
    (sel_w == dma_flag_pkg::SEL_STATUS) ? flags_w :
    (sel_w == dma_flag_pkg::SEL_PEND)   ? pend_r  :
    (sel_w == dma_flag_pkg::SEL_MASK)   ? mask_r  :
    32'h00000000;

  // ----------------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------------
  // Data and error are captured at the setup edge so every output is a flop
  assign pready_nxt  = setup_w;
  assign prdata_nxt  = (setup_w & ~pwrite_i) ? read_mux_w : 32'h00000000;
  assign pslverr_nxt = setup_w & (sel_w == dma_flag_pkg::SEL_NONE);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Flag clear register
  // ----------------------------------------------------------------------
  // Write-only: ones become a one-cycle clear pulse, the word never stores
  assign clear_word_w = (wr_done_w && sel_w == dma_flag_pkg::SEL_CLEAR) ?
                        (pwdata_i & byte_mask_w) : `CLEAR_RST;
  assign clear_nxt    = clear_word_w;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clear_r <= `CLEAR_RST;
    end else begin
      clear_r <= clear_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel flag cells
  // ----------------------------------------------------------------------
  // Channel n owns bits 4n..4n+3; its clear nibble sits at the same place
  generate
    for (gi = 0; gi < `NUM_CHAN; gi++) begin : g_chan
      chan_flag_cell u_cell (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .cpl_event_i  (transfer_complete_event_i[gi]),
        .half_event_i (half_transfer_event_i[gi]),
        .err_event_i  (transfer_error_event_i[gi]),
        .clear_i      (clear_word_w[gi*4 +: 4]),
        .flags_o      (flags_w[gi*4 +: 4])
      );
      assign event_w[gi*4 + `FLD_ANY]  = transfer_complete_event_i[gi] |
                                         half_transfer_event_i[gi] |
                                         transfer_error_event_i[gi];
      assign event_w[gi*4 + `FLD_CPL]  = transfer_complete_event_i[gi];
      assign event_w[gi*4 + `FLD_HALF] = half_transfer_event_i[gi];
      assign event_w[gi*4 + `FLD_ERR]  = transfer_error_event_i[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt pending and mask
  // ----------------------------------------------------------------------
  // A read clears only the bits it returned, so a later event is kept
  assign pend_nxt = event_w | (pend_r &
                    ~((rd_done_w && sel_w == dma_flag_pkg::SEL_PEND) ?
                      prdata_r : 32'h00000000));
  assign mask_nxt = (wr_done_w && sel_w == dma_flag_pkg::SEL_MASK) ?
                    ((pwdata_i & byte_mask_w) | (mask_r & ~byte_mask_w)) : mask_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= `PEND_RST;
      mask_r <= `MASK_RST;
      irq_r  <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      mask_r <= mask_nxt;
      irq_r  <= |(pend_r & mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // Channel group strobes
  // ----------------------------------------------------------------------
  // One-cycle pulse after a completed access; group registers live elsewhere
  assign gsel_nxt = (done_w && sel_w == dma_flag_pkg::SEL_GROUP) ?
                    group_hit_w : 8'h00;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gsel_r <= 8'h00;
      goff_r <= 5'h00;
      gwr_r  <= 1'b0;
    end else begin
      gsel_r <= gsel_nxt;
      goff_r <= group_off_w[8];
      gwr_r  <= wr_done_w;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o          = prdata_r;
  assign pready_o          = pready_r;
  assign pslverr_o         = pslverr_r;
  assign dma_flag_status_o = flags_w;
  assign dma_flag_clear_o  = clear_r;
  assign chan_group_sel_o  = gsel_r;
  assign chan_group_off_o  = goff_r;
  assign chan_group_wr_o   = gwr_r;
  assign irq_o             = irq_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Bus timing and the clear pulse
  AST_ONE_WAIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("access phase length wrong");

  AST_CLEAR_PULSE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && pwrite_i && paddr_i == `DMA_CLEAR_OFS && pstrb_i == 4'hf
    |=> dma_flag_clear_o == $past(pwdata_i) ##1 dma_flag_clear_o == 32'h00000000)
    else $error("clear pulse wrong");

  // Write-only register reads zero
  AST_READ_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && !pwrite_i && paddr_i == `DMA_CLEAR_OFS |-> prdata_o == 32'h00000000
    && !pslverr_o)
    else $error("clear register read not zero");

  // Flag layout
  AST_LAYOUT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    transfer_error_event_i[7] && half_transfer_event_i[3]
    |=> dma_flag_status_o[31] && dma_flag_status_o[28] && dma_flag_status_o[14])
    else $error("flag layout wrong");

  // Group decode at the last group and inside group one
  AST_LAST_GROUP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && paddr_i == `CHAN_GROUP_LAST_OFS |=> chan_group_sel_o == 8'h80
    && chan_group_off_o == 5'h00)
    else $error("last group decode wrong");

  AST_GROUP1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && paddr_i == 12'h020 |=> chan_group_sel_o == 8'h02
    && chan_group_off_o == 5'h04)
    else $error("group one decode wrong");

  // Summary clears and pending
  AST_STATUS_ALL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && pwrite_i && paddr_i == `DMA_CLEAR_OFS && pwdata_i == 32'h11111111
    && pstrb_i == 4'hf && event_w == 32'h00000000 |=> dma_flag_status_o == 32'h00000000)
    else $error("summary clears left flags");

  AST_PEND_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    transfer_complete_event_i[0] |=> pend_r[`FLD_CPL] && pend_r[`FLD_ANY]
    ##1 (irq_o || !($past(mask_r[`FLD_CPL]) || $past(mask_r[`FLD_ANY]))))
    else $error("event not pending");

  // ----------------------------------------------------------------------
  // Answer, strobe and pending checks
  // ----------------------------------------------------------------------
  // Misaligned setups answer with an error
  AST_SLVERR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    setup_w && paddr_i[1:0] != 2'b00 |=> pslverr_o && pready_o)
    else $error("missing bus error");

  // No clear pulse without a finished write
  AST_CLEAR_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_done_w |=> dma_flag_clear_o == 32'h00000000)
    else $error("clear pulse without write");

  // Read data stands only with pready
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pready_o |-> prdata_o == 32'h00000000)
    else $error("read data outside access");

  AST_WDATA_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && pwrite_i |-> prdata_o == 32'h00000000)
    else $error("data on a write");

  // A pending read never hides a new event
  AST_PEND_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    event_w != 32'h00000000 |=> (pend_r & $past(event_w)) == $past(event_w))
    else $error("event missing from pending");

  // Status ignores bus writes
  AST_STATUS_RO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && pwrite_i && paddr_i == `DMA_STATUS_OFS && event_w == 32'h00000000
    |=> dma_flag_status_o == $past(dma_flag_status_o))
    else $error("status changed by write");

  // Group select: one-hot after a group access, idle otherwise
  AST_GROUP_ONEHOT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_w && aligned_w && group_hit_w != 8'h00 |=> $onehot(chan_group_sel_o))
    else $error("group select not one-hot");

  AST_GROUP_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !done_w |=> chan_group_sel_o == 8'h00)
    else $error("stray group select");

endmodule : dma_flag_clear_logic

// ---- verif/dma_flag_clear_logic_tb.sv ----
// Self-checking bench of the DMA flag status and write-one-to-clear block
`timescale 1ns/1ps
`include "dma_flag_params.svh"

module testbench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk_i;
  logic        sys_rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  cpl_ev;
  logic [7:0]  half_ev;
  logic [7:0]  err_ev;
  logic [31:0] dma_flag_status_o;
  logic [31:0] dma_flag_clear_o;
  logic [7:0]  chan_group_sel_o;
  logic [4:0]  chan_group_off_o;
  logic        chan_group_wr_o;
  logic        irq_o;
  // Bench state
  int          errors;
  int          samples_checked;
  int          n;
  int          f;
  logic [31:0] exp_st;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  acc_cpl;
  logic [31:0] snap_clr;
  logic [7:0]  snap_sel;
  logic [4:0]  snap_off;
  logic        snap_wr;
  logic [3:0]  nib;
  logic [31:0] word;
  logic [7:0]  one;

  // ----------------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------------
  dma_flag_clear_logic DUT (
    .clk_i                     (clk_i),
    .sys_rst_i                 (sys_rst_i),
    .psel_i                    (psel_i),
    .penable_i                 (penable_i),
    .pwrite_i                  (pwrite_i),
    .paddr_i                   (paddr_i),
    .pwdata_i                  (pwdata_i),
    .pstrb_i                   (pstrb_i),
    .prdata_o                  (prdata_o),
    .pready_o                  (pready_o),
    .pslverr_o                 (pslverr_o),
    .transfer_complete_event_i (cpl_ev),
    .half_transfer_event_i     (half_ev),
    .transfer_error_event_i    (err_ev),
    .dma_flag_status_o         (dma_flag_status_o),
    .dma_flag_clear_o          (dma_flag_clear_o),
    .chan_group_sel_o          (chan_group_sel_o),
    .chan_group_off_o          (chan_group_off_o),
    .chan_group_wr_o           (chan_group_wr_o),
    .irq_o                     (irq_o)
  );

  // 50 MHz system clock
  always #10 clk_i = ~clk_i;

  // ----------------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------------
  task complete_run;
    $display("samples_checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit

  // ----------------------------------------------------------------------
  // APB transfer; strobes that follow completion are snapshotted 1 ns later
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                     input logic [3:0] strb);
    int i;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= addr;
    pwdata_i  <= data;
    pstrb_i   <= strb;
    @(posedge clk_i);
    penable_i <= 1'b1;
    cpl_ev    <= acc_cpl;  // Optional event racing the access edge
    // pready is read at the edge, before that edge updates it
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      $display("unexpected at %0t: no bus answer", $time);
      complete_run();
    end else begin
      rd  = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      cpl_ev    <= 8'h00;
      #1;
      snap_clr = dma_flag_clear_o;
      snap_sel = chan_group_sel_o;
      snap_off = chan_group_off_o;
      snap_wr  = chan_group_wr_o;
    end
  endtask : apb

  // One-cycle event pulses; expected flags follow the nibble layout
  task automatic pulse(input logic [7:0] c, input logic [7:0] h, input logic [7:0] e);
    @(posedge clk_i);
    cpl_ev  <= c;
    half_ev <= h;
    err_ev  <= e;
    @(posedge clk_i);
    cpl_ev  <= 8'h00;
    half_ev <= 8'h00;
    err_ev  <= 8'h00;
    for (int k = 0; k < 8; k++) begin
      exp_st[4*k+`FLD_ANY]  = exp_st[4*k+`FLD_ANY] | c[k] | h[k] | e[k];
      exp_st[4*k+`FLD_CPL]  = exp_st[4*k+`FLD_CPL] | c[k];
      exp_st[4*k+`FLD_HALF] = exp_st[4*k+`FLD_HALF] | h[k];
      exp_st[4*k+`FLD_ERR]  = exp_st[4*k+`FLD_ERR] | e[k];
    end
    #1;
  endtask : pulse

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0; sys_rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 12'h000; pwdata_i = 32'h00000000; pstrb_i = 4'h0;
    cpl_ev = 8'h00; half_ev = 8'h00; err_ev = 8'h00; acc_cpl = 8'h00;
    errors = 0; samples_checked = 0; exp_st = 32'h00000000;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    check_word(dma_flag_status_o, 32'h00000000, "status after reset");
    check_word(dma_flag_clear_o, `CLEAR_RST, "clear strobes after reset");
    apb(1'b0, `DMA_CLEAR_OFS, 32'h00000000, 4'h0);
    check_word(rd, `CLEAR_RST, "clear register read");
    // One event kind per channel, rotating, pins down the bit map
    for (n = 0; n < 8; n++) begin
      one = 8'h01 << n;
      pulse((n % 3 == 0) ? one : 8'h00, (n % 3 == 1) ? one : 8'h00,
            (n % 3 == 2) ? one : 8'h00);
      check_word(dma_flag_status_o, exp_st, "status after event");
    end
    apb(1'b0, `DMA_STATUS_OFS, 32'h00000000, 4'h0);
    check_word(rd, exp_st, "status read");
    pulse(8'hff, 8'hff, 8'hff);
    check_word(dma_flag_status_o, 32'hffffffff, "all flags set");
    // Field clears on even channels; summary flag must survive them
    for (f = 1; f < 4; f++) begin
      nib  = 4'h1 << f;
      word = {8{nib}} & 32'h0f0f0f0f;
      apb(1'b1, `DMA_CLEAR_OFS, word, 4'hf);
      exp_st = exp_st & ~word;
      check_word(snap_clr, word, "clear strobe copy");
      check_word(dma_flag_status_o, exp_st, "status after field clear");
    end
    @(posedge clk_i);
    #1;
    check_word(dma_flag_clear_o, 32'h00000000, "clear strobe lasts one cycle");
    apb(1'b1, `DMA_CLEAR_OFS, 32'h00000000, 4'hf);
    check_word(dma_flag_status_o, exp_st, "zero write keeps flags");
    // Byte lane 0 only, then summary clears on all eight channels
    apb(1'b1, `DMA_CLEAR_OFS, 32'hffffffff, 4'b0001);
    exp_st = exp_st & 32'hffffff00;
    check_word(snap_clr, 32'h000000ff, "lane masked clear copy");
    check_word(dma_flag_status_o, exp_st, "status after lane clear");
    apb(1'b1, `DMA_CLEAR_OFS, 32'h11111111, 4'hf);
    exp_st = 32'h00000000;
    check_word(dma_flag_status_o, exp_st, "summary clears whole nibble");
    // Complete event on channel 0 in the very cycle of a full clear
    acc_cpl = 8'h01;
    apb(1'b1, `DMA_CLEAR_OFS, 32'hffffffff, 4'hf);
    acc_cpl = 8'h00;
    exp_st = 32'h00000003;
    check_word(dma_flag_status_o, exp_st, "set beats clear");
    // Refused and ignored accesses
    apb(1'b0, 12'h0b0, 32'h00000000, 4'h0);
    check_bit(err, 1'b1, "unmapped read error");
    check_word(rd, 32'h00000000, "unmapped read data");
    apb(1'b1, 12'h006, 32'hffffffff, 4'hf);
    check_bit(err, 1'b1, "unaligned write error");
    check_word(dma_flag_status_o, exp_st, "unaligned clear ignored");
    apb(1'b1, `DMA_STATUS_OFS, 32'hffffffff, 4'hf);
    check_word(dma_flag_status_o, exp_st, "status write ignored");
    // Channel group strobes, reads and writes alternating
    for (n = 0; n < 8; n++) begin
      apb(n % 2, 12'(8 + 20 * n + 4 * ((4 * n + 2) % 5)), 32'h00000000, 4'hf);
      check_word(32'(snap_sel), 32'(8'h01 << n), "group select");
      check_word(32'(snap_off), 32'(4 * ((4 * n + 2) % 5)), "group offset");
      check_bit(snap_wr, (n % 2 == 1), "group write strobe");
      check_bit(err, 1'b0, "group access error");
    end
    // Interrupt: pending read clears, mask selects channel 0 complete only
    apb(1'b0, `IRQ_PEND_OFS, 32'h00000000, 4'h0);
    apb(1'b0, `IRQ_PEND_OFS, 32'h00000000, 4'h0);
    check_word(rd, 32'h00000000, "pending after read");
    apb(1'b1, `IRQ_MASK_OFS, 32'h00000002, 4'hf);
    apb(1'b0, `IRQ_MASK_OFS, 32'h00000000, 4'h0);
    check_word(rd, 32'h00000002, "mask read back");
    pulse(8'h00, 8'h01, 8'h00);
    @(posedge clk_i);
    #1;
    check_bit(irq_o, 1'b0, "masked event no irq");
    pulse(8'h01, 8'h00, 8'h00);
    check_bit(irq_o, 1'b0, "irq not yet");
    @(posedge clk_i);
    #1;
    check_bit(irq_o, 1'b1, "irq raised");
    apb(1'b0, `IRQ_PEND_OFS, 32'h00000000, 4'h0);
    check_word(rd, 32'h00000007, "pending image");
    @(posedge clk_i);
    #1;
    check_bit(irq_o, 1'b0, "irq dropped after pending read");
    check_word(dma_flag_status_o, exp_st, "status kept by pending read");
    // Reset in mid-run wipes the flags
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    check_word(dma_flag_status_o, 32'h00000000, "status after second reset");
    check_bit(irq_o, 1'b0, "irq after second reset");
    complete_run();
  end
endmodule : testbench
